// *** pld_diag_map.svh ***
`ifndef PLD_DIAG_MAP_SVH
`define PLD_DIAG_MAP_SVH
// ==========================================
// Register byte offsets
`define PLD_REG_LB       8'h00
`define PLD_REG_DCLK     8'h04
`define PLD_REG_FRAME_GEN_ENABLE    8'h08
`define PLD_REG_FG_TYPE  8'h0C
`define PLD_REG_FG_LEN   8'h10
`define PLD_REG_FG_NUM   8'h14
`define PLD_REG_FRAME_GEN_DONE  8'h18
`define PLD_REG_FRAME_CHECK_ENABLE    8'h1C
`define PLD_REG_FC_SEL   8'h20
`define PLD_REG_RXERR    8'h24
`define PLD_REG_FCNT_H   8'h28
`define PLD_REG_FCNT_L   8'h2C
`define PLD_REG_CNT0     8'h30
`define PLD_REG_CNT_LAST 8'h4C
`define PLD_REG_PD       8'h50
`define PLD_REG_STAT     8'h54
`define PLD_REG_AN       8'h58
`define PLD_REG_FRC      8'h5C
`define PLD_REG_TM       8'h60
`define PLD_REG_PMA      8'h64
// ==========================================
// Field positions and reset values
`define PLD_LB_REM       0
`define PLD_LB_SUP       1
`define PLD_LB_RMII      2
`define PLD_TM_MSB       15
`define PLD_TM_LSB       13
`define PLD_LB_RST       3'h2
`define PLD_AN_RST       1'h1
`define PLD_FG_LEN_RST   16'h0040
`define PLD_FG_NUM_RST   16'h0001
// ==========================================
// Modes, codes and counts
`define PLD_TM_ALT       3'h1
`define PLD_TM_DROOP     3'h2
`define PLD_TM_IDLE      3'h3
`define PLD_SYM_ZERO     2'h0
`define PLD_SYM_PLUS     2'h1
`define PLD_SYM_MINUS    2'h3
`define PLD_DROOP_LAST   4'h9
`define PLD_NIB_LAST     6'h31
`define PLD_PRE_NIB      4'h5
`define PLD_SFD_NIB      4'hD
`define PLD_PRE_LAST     16'h000F
`define PLD_FCS_BYTES    16'h0004
`define PLD_FCS_LAST     16'h0007
`define PLD_IFG_LAST     16'h0017
`define PLD_LEN_LO       16'h0018
`define PLD_LEN_HI       16'h001B
`define PLD_CRC_INIT     32'hFFFF_FFFF
`define PLD_CRC_RES      32'hDEBB_20E3
`define PLD_MIN_FRAME    16'h0040
`define PLD_MAX_FRAME    16'h05EE
`define PLD_MAX_LENF     16'h05DC
`define PLD_HDR_FCS      16'h0012
`define PLD_LFSR_SEED    16'hACE1
`define PLD_CI_LEN       0
`define PLD_CI_ALGN      1
`define PLD_CI_SYM       2
`define PLD_CI_OSZ       3
`define PLD_CI_USZ       4
`define PLD_CI_ODDN      5
`define PLD_CI_ODDP      6
`define PLD_CI_FCAR      7
`define PLD_NCNT         8
`endif

// *** pld_pkg.sv ***
package pld_pkg;
    // ==========================================
    // Types
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } pld_mii_s;

    typedef logic [1:0] pld_sym_t;

    typedef enum logic [2:0] {FG_IDLE, FG_PRE, FG_DATA, FG_FCS, FG_GAP} pld_fg_e;

    // ==========================================
    // Reflected CRC-32 over one nibble, low bit first
    function automatic logic [31:0] pld_crc_nib(input logic [31:0] crc, input logic [3:0] nib);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 4; i++) begin
            c = (c[0] ^ nib[i]) ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// *** pld_diag_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pld_diag_map.svh"

module pld_diag_top
    import pld_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    input  wire logic        link_up,
    input  wire pld_mii_s    mac_tx,
    input  wire pld_mii_s    line_rx,
    input  wire logic        line_bad_ssd,
    input  wire logic        sym_tick,
    input  wire pld_sym_t    pcs_sym,
    output pld_mii_s         mac_rx,
    output pld_mii_s         line_tx,
    output pld_sym_t         pma_sym,
    output logic             soft_power_down,
    output logic             autoneg_enable,
    output logic             autoneg_forced_mode,
    output logic             rmii_tx_check_enable,
    output logic             diagnostic_clock_enable
);
    // ==========================================
    // Nibble-rate divider
    logic [5:0] div_q;
    wire        nib_tick = (div_q == `PLD_NIB_LAST);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) div_q <= 6'h00;
        else       div_q <= nib_tick ? 6'h00 : div_q + 6'h01;
    end

    // ==========================================
    // Wishbone slave, one wait state
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rd_word;
    wire         req     = wb_cyc_i & wb_stb_i;
    wire         take    = req & ~ack_q;
    wire         rd_take = take & ~wb_we_i;
    wire         wr      = req & ack_q & wb_we_i;
    wire  [7:0]  off     = {wb_adr_i[7:2], 2'b00};
    wire         wr0     = wr & wb_sel_i[0];
    wire         wr1     = wr & wb_sel_i[1];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= take;
            rdat_q <= take ? rd_word : rdat_q;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ==========================================
    // Control registers
    logic [2:0]  lb_q;
    logic        dclk_q, fgen_q, fgdone_q, fcen_q, fcsel_q;
    logic        pd_q, pdrdy_q, an_q, frc_q, txdis_q;
    logic [1:0]  fgtype_q;
    logic [15:0] fglen_q, fgnum_q;
    logic [2:0]  tm_q;
    logic        fg_fin;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lb_q     <= `PLD_LB_RST;
            dclk_q   <= 1'b0;
            fgen_q   <= 1'b0;
            fgtype_q <= 2'h0;
            fglen_q  <= `PLD_FG_LEN_RST;
            fgnum_q  <= `PLD_FG_NUM_RST;
            fcen_q   <= 1'b0;
            fcsel_q  <= 1'b0;
            pd_q     <= 1'b0;
            an_q     <= `PLD_AN_RST;
            frc_q    <= 1'b0;
            tm_q     <= 3'h0;
            txdis_q  <= 1'b0;
        end else begin
            if (wr0 && hit(off, `PLD_REG_LB))      lb_q <= wb_dat_i[2:0];
            if (wr0 && hit(off, `PLD_REG_DCLK))    dclk_q <= wb_dat_i[0];
            if (wr0 && hit(off, `PLD_REG_FRAME_GEN_ENABLE))   fgen_q <= wb_dat_i[0];
            else if (fg_fin)                       fgen_q <= 1'b0;
            if (wr0 && hit(off, `PLD_REG_FG_TYPE)) fgtype_q <= wb_dat_i[1:0];
            if (wr0 && hit(off, `PLD_REG_FG_LEN))  fglen_q[7:0] <= wb_dat_i[7:0];
            if (wr1 && hit(off, `PLD_REG_FG_LEN))  fglen_q[15:8] <= wb_dat_i[15:8];
            if (wr0 && hit(off, `PLD_REG_FG_NUM))  fgnum_q[7:0] <= wb_dat_i[7:0];
            if (wr1 && hit(off, `PLD_REG_FG_NUM))  fgnum_q[15:8] <= wb_dat_i[15:8];
            if (wr0 && hit(off, `PLD_REG_FRAME_CHECK_ENABLE))   fcen_q <= wb_dat_i[0];
            if (wr0 && hit(off, `PLD_REG_FC_SEL))  fcsel_q <= wb_dat_i[0];
            if (wr0 && hit(off, `PLD_REG_PD))      pd_q <= wb_dat_i[0];
            if (wr0 && hit(off, `PLD_REG_AN))      an_q <= wb_dat_i[0];
            if (wr0 && hit(off, `PLD_REG_FRC))     frc_q <= wb_dat_i[0];
            if (wr1 && hit(off, `PLD_REG_TM))      tm_q <= wb_dat_i[`PLD_TM_MSB:`PLD_TM_LSB];
            if (wr0 && hit(off, `PLD_REG_PMA))     txdis_q <= wb_dat_i[0];
        end
    end

    // Done: hardware set wins over write-one-to-clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fgdone_q <= 1'b0;
            pdrdy_q  <= 1'b0;
        end else begin
            fgdone_q <= fg_fin | (fgdone_q & ~(wr0 & hit(off, `PLD_REG_FRAME_GEN_DONE) & wb_dat_i[0]));
            pdrdy_q  <= pd_q;
        end
    end

    assign soft_power_down         = pd_q;
    assign autoneg_enable          = an_q;
    assign autoneg_forced_mode     = frc_q;
    assign rmii_tx_check_enable    = lb_q[`PLD_LB_RMII];
    assign diagnostic_clock_enable = dclk_q;

    // ==========================================
    // Frame generator
    pld_fg_e     fg_state_q;
    logic [15:0] fg_cnt_q, fg_frames_q, fg_lfsr_q;
    logic [31:0] fg_crc_q;
    pld_mii_s    fg_tx_q;
    logic [3:0]  fg_pay;
    wire         fg_tick   = nib_tick & dclk_q;
    wire  [15:0] len_pay   = fglen_q - `PLD_FCS_BYTES;
    wire  [15:0] data_nibs = (fglen_q > `PLD_FCS_BYTES) ? {len_pay[14:0], 1'b0} : 16'h0000;
    wire         fg_lastfr = (fgnum_q != 16'h0000) && (fg_frames_q == fgnum_q);
    wire         fg_on     = fgen_q | (fg_state_q != FG_IDLE);

    assign fg_fin = fg_tick & (fg_state_q == FG_GAP) & (fg_cnt_q == `PLD_IFG_LAST) & fg_lastfr;

    always_comb begin
        unique case (fgtype_q)
            2'h0: fg_pay = fg_lfsr_q[3:0];
            2'h1: fg_pay = 4'hF;
            2'h2: fg_pay = fg_cnt_q[3:0];
            2'h3: fg_pay = 4'h0;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fg_state_q  <= FG_IDLE;
            fg_cnt_q    <= 16'h0000;
            fg_frames_q <= 16'h0000;
            fg_lfsr_q   <= `PLD_LFSR_SEED;
            fg_crc_q    <= `PLD_CRC_INIT;
            fg_tx_q     <= '0;
        end else if (fg_tick) begin
            fg_cnt_q <= fg_cnt_q + 16'h0001;
            unique case (fg_state_q)
                FG_IDLE: begin
                    fg_tx_q  <= '0;
                    fg_cnt_q <= 16'h0000;
                    if (fgen_q) begin
                        fg_state_q  <= FG_PRE;
                        fg_frames_q <= 16'h0000;
                    end
                end
                FG_PRE: begin
                    fg_tx_q <= '{1'b1, 1'b0, (fg_cnt_q == `PLD_PRE_LAST) ? `PLD_SFD_NIB : `PLD_PRE_NIB};
                    fg_crc_q <= `PLD_CRC_INIT;
                    if (fg_cnt_q == `PLD_PRE_LAST) begin
                        fg_cnt_q   <= 16'h0000;
                        fg_state_q <= (data_nibs == 16'h0000) ? FG_FCS : FG_DATA;
                    end
                end
                FG_DATA: begin
                    fg_tx_q   <= '{1'b1, 1'b0, fg_pay};
                    fg_crc_q  <= pld_crc_nib(fg_crc_q, fg_pay);
                    fg_lfsr_q <= {fg_lfsr_q[14:0], fg_lfsr_q[15] ^ fg_lfsr_q[13] ^ fg_lfsr_q[12] ^ fg_lfsr_q[10]};
                    if (fg_cnt_q == data_nibs - 16'h0001) begin
                        fg_cnt_q   <= 16'h0000;
                        fg_state_q <= FG_FCS;
                    end
                end
                FG_FCS: begin
                    fg_tx_q  <= '{1'b1, 1'b0, ~fg_crc_q[3:0]};
                    fg_crc_q <= fg_crc_q >> 4;
                    if (fg_cnt_q == `PLD_FCS_LAST) begin
                        fg_cnt_q    <= 16'h0000;
                        fg_frames_q <= fg_frames_q + 16'h0001;
                        fg_state_q  <= FG_GAP;
                    end
                end
                FG_GAP: begin
                    fg_tx_q <= '0;
                    if (fg_cnt_q == `PLD_IFG_LAST) begin
                        fg_cnt_q   <= 16'h0000;
                        fg_state_q <= (fg_lastfr || !fgen_q) ? FG_IDLE : FG_PRE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Data path steering
    wire rlb_on = lb_q[`PLD_LB_REM] & link_up;
    wire sup_on = rlb_on & lb_q[`PLD_LB_SUP];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            line_tx <= '0;
            mac_rx  <= '0;
        end else begin
            line_tx <= pd_q ? '0 : fg_on ? fg_tx_q : rlb_on ? line_rx : mac_tx;
            mac_rx  <= sup_on ? '0 : line_rx;
        end
    end

    // ==========================================
    // Frame checker
    pld_mii_s    src;
    logic        inf_q, sfd_q, ser_q, ssd_q;
    logic [15:0] pre_q, nib_q, lenf_q;
    logic [31:0] ck_crc_q;
    assign src = fcsel_q ? mac_tx : line_rx;
    wire         fc_run  = fcen_q & dclk_q;
    wire         ck_tick = nib_tick & fc_run;
    wire         pk_end  = ck_tick & ~src.en & inf_q;
    wire         fc_end  = pk_end & sfd_q;
    wire  [15:0] bytes   = {1'b0, nib_q[15:1]};
    wire  [15:0] lenfld  = {lenf_q[7:0], lenf_q[15:8]};
    wire         crc_bad = (ck_crc_q != `PLD_CRC_RES);
    wire  [15:0] lidx    = nib_q - `PLD_LEN_LO;
    wire         in_lenf = (nib_q >= `PLD_LEN_LO) && (nib_q <= `PLD_LEN_HI);
    wire         ssd_new = fc_run & line_bad_ssd & ~ssd_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            inf_q    <= 1'b0;
            sfd_q    <= 1'b0;
            ser_q    <= 1'b0;
            pre_q    <= 16'h0000;
            nib_q    <= 16'h0000;
            lenf_q   <= 16'h0000;
            ck_crc_q <= `PLD_CRC_INIT;
        end else if (ck_tick) begin
            if (src.en) begin
                inf_q <= 1'b1;
                ser_q <= ser_q | src.er;
                if (!sfd_q) begin
                    pre_q <= pre_q + 16'h0001;
                    sfd_q <= (src.d == `PLD_SFD_NIB);
                end else begin
                    nib_q    <= nib_q + 16'h0001;
                    ck_crc_q <= pld_crc_nib(ck_crc_q, src.d);
                    if (in_lenf) lenf_q[{lidx[1:0], 2'b00} +: 4] <= src.d;
                end
            end else begin
                inf_q    <= 1'b0;
                sfd_q    <= 1'b0;
                ser_q    <= 1'b0;
                pre_q    <= 16'h0000;
                nib_q    <= 16'h0000;
                lenf_q   <= 16'h0000;
                ck_crc_q <= `PLD_CRC_INIT;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) ssd_q <= 1'b0;
        else       ssd_q <= line_bad_ssd;
    end

    // ==========================================
    // Counters and read snapshot
    logic [`PLD_NCNT-1:0] inc;
    logic [15:0]          cnt_q  [`PLD_NCNT];
    logic [15:0]          snap_q [`PLD_NCNT];
    logic [15:0]          rxerr_q;
    logic [31:0]          frm_q, frmsnap_q;
    wire                  latch = rd_take & hit(off, `PLD_REG_RXERR);

    assign inc[`PLD_CI_LEN]  = fc_end & (lenfld <= `PLD_MAX_LENF) & (lenfld + `PLD_HDR_FCS > bytes);
    assign inc[`PLD_CI_ALGN] = fc_end & nib_q[0] & crc_bad;
    assign inc[`PLD_CI_SYM]  = fc_end & ser_q;
    assign inc[`PLD_CI_OSZ]  = fc_end & (bytes > `PLD_MAX_FRAME);
    assign inc[`PLD_CI_USZ]  = fc_end & (bytes < `PLD_MIN_FRAME);
    assign inc[`PLD_CI_ODDN] = fc_end & nib_q[0];
    assign inc[`PLD_CI_ODDP] = pk_end & pre_q[0];
    assign inc[`PLD_CI_FCAR] = ssd_new;

    for (genvar k = 0; k < `PLD_NCNT; k++) begin : g_cnt
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                cnt_q[k]  <= 16'h0000;
                snap_q[k] <= 16'h0000;
            end else begin
                cnt_q[k]  <= cnt_q[k] + {15'h0000, inc[k]};
                snap_q[k] <= latch ? cnt_q[k] : snap_q[k];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rxerr_q   <= 16'h0000;
            frm_q     <= 32'h0000_0000;
            frmsnap_q <= 32'h0000_0000;
        end else begin
            rxerr_q   <= rxerr_q + {15'h0000, fc_end & crc_bad};
            frm_q     <= frm_q + {31'h0000_0000, fc_end};
            frmsnap_q <= latch ? frm_q : frmsnap_q;
        end
    end

    // ==========================================
    // Transmit symbol override
    logic       pol_q;
    logic [3:0] dr_q;
    wire        tm_live = ~pd_q & ~txdis_q;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pol_q   <= 1'b0;
            dr_q    <= 4'h0;
            pma_sym <= `PLD_SYM_ZERO;
        end else begin
            if (sym_tick && tm_live && tm_q == `PLD_TM_ALT) pol_q <= ~pol_q;
            if (sym_tick && tm_live && tm_q == `PLD_TM_DROOP) begin
                dr_q  <= (dr_q == `PLD_DROOP_LAST) ? 4'h0 : dr_q + 4'h1;
                pol_q <= (dr_q == `PLD_DROOP_LAST) ? ~pol_q : pol_q;
            end
            if (pd_q || txdis_q)
                pma_sym <= `PLD_SYM_ZERO;
            else if (tm_q == `PLD_TM_ALT || tm_q == `PLD_TM_DROOP)
                pma_sym <= pol_q ? `PLD_SYM_MINUS : `PLD_SYM_PLUS;
            else
                pma_sym <= pcs_sym;
        end
    end

    // ==========================================
    // Register read mux
    wire [7:0] cdiff  = off - `PLD_REG_CNT0;
    wire       in_cnt = (off >= `PLD_REG_CNT0) && (off <= `PLD_REG_CNT_LAST);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_cnt) rd_word = {16'h0000, snap_q[cdiff[4:2]]};
        else begin
            case (off)
                `PLD_REG_LB:      rd_word = {29'h0000_0000, lb_q};
                `PLD_REG_DCLK:    rd_word = {31'h0000_0000, dclk_q};
                `PLD_REG_FRAME_GEN_ENABLE:   rd_word = {31'h0000_0000, fgen_q};
                `PLD_REG_FG_TYPE: rd_word = {30'h0000_0000, fgtype_q};
                `PLD_REG_FG_LEN:  rd_word = {16'h0000, fglen_q};
                `PLD_REG_FG_NUM:  rd_word = {16'h0000, fgnum_q};
                `PLD_REG_FRAME_GEN_DONE: rd_word = {31'h0000_0000, fgdone_q};
                `PLD_REG_FRAME_CHECK_ENABLE:   rd_word = {31'h0000_0000, fcen_q};
                `PLD_REG_FC_SEL:  rd_word = {31'h0000_0000, fcsel_q};
                `PLD_REG_RXERR:   rd_word = {16'h0000, rxerr_q};
                `PLD_REG_FCNT_H:  rd_word = {16'h0000, frmsnap_q[31:16]};
                `PLD_REG_FCNT_L:  rd_word = {16'h0000, frmsnap_q[15:0]};
                `PLD_REG_PD:      rd_word = {31'h0000_0000, pd_q};
                `PLD_REG_STAT:    rd_word = {31'h0000_0000, pdrdy_q};
                `PLD_REG_AN:      rd_word = {31'h0000_0000, an_q};
                `PLD_REG_FRC:     rd_word = {31'h0000_0000, frc_q};
                `PLD_REG_TM:      rd_word = {16'h0000, tm_q, 13'h0000};
                `PLD_REG_PMA:     rd_word = {31'h0000_0000, txdis_q};
                default:          rd_word = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // Checks
    a_fg_owns_line: assert property (@(posedge mclk) disable iff (reset)
        (fg_on && !pd_q) |=> (line_tx == $past(fg_tx_q))) else $error("generator not on line");
    a_rlb_echo: assert property (@(posedge mclk) disable iff (reset)
        (rlb_on && !fg_on && !pd_q) |=> (line_tx == $past(line_rx))) else $error("remote loopback not echoed");
    a_rx_suppress: assert property (@(posedge mclk) disable iff (reset)
        sup_on |=> !mac_rx.en) else $error("line data leaked to MAC");
    a_done_after_last: assert property (@(posedge mclk) disable iff (reset)
        fg_fin |=> (fgdone_q && !fgen_q && fg_state_q == FG_IDLE)) else $error("done flag missing");
    a_tm_alt_toggle: assert property (@(posedge mclk) disable iff (reset)
        (sym_tick && tm_live && tm_q == `PLD_TM_ALT) |=> (pol_q != $past(pol_q))) else $error("pattern stuck");
    a_txdis_zero: assert property (@(posedge mclk) disable iff (reset)
        txdis_q [*2] |-> (pma_sym == `PLD_SYM_ZERO)) else $error("nonzero symbol in disable");
    a_crc_count: assert property (@(posedge mclk) disable iff (reset)
        (fc_end && crc_bad) |=> (rxerr_q == $past(rxerr_q) + 16'h0001)) else $error("crc error not counted");
    a_snap_latch: assert property (@(posedge mclk) disable iff (reset)
        latch |=> (frmsnap_q == $past(frm_q) && snap_q[`PLD_CI_SYM] == $past(cnt_q[`PLD_CI_SYM])))
        else $error("snapshot not latched");
    a_false_carrier: assert property (@(posedge mclk) disable iff (reset)
        ssd_new |=> (cnt_q[`PLD_CI_FCAR] == $past(cnt_q[`PLD_CI_FCAR]) + 16'h0001)) else $error("false carrier lost");
endmodule
`default_nettype wire

// *** pld_remote_phy.sv ***
`timescale 1ns/1ns
`default_nettype none
module pld_remote_phy import pld_pkg::*; (
    input  wire logic     mclk,
    input  wire logic     reset,
    input  wire logic     echo,
    input  wire logic     corrupt,
    input  wire pld_mii_s tx_nib,
    input  wire pld_mii_s dev_tx,
    output var pld_mii_s  line_rx,
    output var logic      sym_tick,
    output var pld_sym_t  pcs_sym
);
    logic [1:0] div_q;
    // ==========================================
    // Far end: echoes our line data or sends its own nibble
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_q    <= '0;
            line_rx  <= '0;
            sym_tick <= 1'b0;
            pcs_sym  <= 2'h0;
        end else begin
            div_q    <= div_q + 2'h1;
            sym_tick <= (div_q == 2'h3);
            pcs_sym  <= 2'h1;
            line_rx  <= echo ? dev_tx : tx_nib;
            // Damages all-ones payload so the CRC no longer holds
            if (echo && corrupt && dev_tx.en && dev_tx.d == 4'hF) begin
                line_rx.d <= 4'h7;
            end
        end
    end
endmodule
`default_nettype wire

// *** phy_loopback_framegen_testmode_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pld_diag_map.svh"
module phy_loopback_framegen_testmode_bench import pld_pkg::*;;
    logic        mclk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic        link_up = 0, line_bad_ssd = 0, echo = 0, corrupt = 0, sym_tick, prev_en = 0;
    logic [7:0]  wb_adr_i = '0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    pld_mii_s    mac_tx = '0, tx_nib = '0, line_rx, mac_rx, line_tx;
    pld_sym_t    pcs_sym, pma_sym;
    pld_sym_t    s [40];
    int          n_mismatch = 0, cmp_count = 0, n_fr = 0, k;
    logic        soft_power_down, autoneg_enable, autoneg_forced_mode, rmii_tx_check_enable, diagnostic_clock_enable;
    wire  [4:0]  lvl = {soft_power_down, autoneg_enable, autoneg_forced_mode, rmii_tx_check_enable,
                        diagnostic_clock_enable};
    pld_diag_top i_dut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
                        .wb_dat_o, .link_up, .mac_tx, .line_rx, .line_bad_ssd, .sym_tick, .pcs_sym, .mac_rx, .line_tx,
                        .pma_sym, .soft_power_down, .autoneg_enable, .autoneg_forced_mode, .rmii_tx_check_enable,
                        .diagnostic_clock_enable);
    pld_remote_phy i_far (.mclk, .reset, .echo, .corrupt, .tx_nib, .dev_tx(line_tx), .line_rx, .sym_tick, .pcs_sym);
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (line_tx.en && !prev_en) n_fr++;
        prev_en = line_tx.en;
    end
    // ==========================================
    // Bus and compare helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, '0);
        chk(q, e);
    endtask
    task automatic syms;
        int i;
        i = 0;
        while (i < 40) begin
            @(posedge mclk);
            if (sym_tick === 1'b1) begin
                @(negedge mclk);
                s[i] = pma_sym;
                i++;
            end
        end
        @(posedge mclk);
    endtask
    task automatic done_wait;
        for (int i = 0; i < 300; i++) begin
            repeat (100) @(posedge mclk);
            wb(1'b0, `PLD_REG_FRAME_GEN_DONE, '0);
            if (q[0] === 1'b1) break;
        end
        chk(q, 32'h1);
        repeat (200) @(posedge mclk);
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        report_and_stop;
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(`PLD_REG_LB, 32'h2);
        rd(8'hFC, 32'h0);
        rd(`PLD_REG_FG_LEN, `PLD_FG_LEN_RST);
        link_up <= 1'b1;
        tx_nib  <= 6'h2A;
        mac_tx  <= 6'h25;
        wb(1'b1, `PLD_REG_LB, 32'h3);
        repeat (4) @(posedge mclk);
        chk(line_tx, 6'h2A);
        chk(mac_rx, 6'h00);
        wb(1'b1, `PLD_REG_LB, 32'h4);
        repeat (4) @(posedge mclk);
        chk(line_tx, 6'h25);
        chk(mac_rx, 6'h2A);
        chk(lvl, 32'hA);
        mac_tx <= 6'h0F;
        echo   <= 1'b1;
        wb(1'b1, `PLD_REG_FG_TYPE, 32'h1);
        wb(1'b1, `PLD_REG_FG_NUM, 32'h2);
        wb(1'b1, `PLD_REG_FRAME_CHECK_ENABLE, 32'h1);
        wb(1'b1, `PLD_REG_DCLK, 32'h1);
        k = n_fr;
        wb(1'b1, `PLD_REG_FRAME_GEN_ENABLE, 32'h1);
        done_wait;
        chk(n_fr - k, 32'h2);
        repeat (2) begin
            line_bad_ssd <= 1'b1;
            repeat (3) @(posedge mclk);
            line_bad_ssd <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        rd(`PLD_REG_RXERR, 32'h0);
        rd(`PLD_REG_FCNT_L, 32'h2);
        rd(`PLD_REG_FCNT_H, 32'h0);
        rd(`PLD_REG_CNT_LAST, 32'h2);
        for (int i = 0; i < 7; i++) rd(`PLD_REG_CNT0 + 8'(4 * i), 32'h0);
        rd(`PLD_REG_FRAME_GEN_ENABLE, 32'h0);
        rd(`PLD_REG_FRAME_GEN_DONE, 32'h1);
        wb(1'b1, `PLD_REG_FRAME_GEN_DONE, 32'h1);
        rd(`PLD_REG_FRAME_GEN_DONE, 32'h0);
        corrupt <= 1'b1;
        wb(1'b1, `PLD_REG_FG_NUM, 32'h1);
        wb(1'b1, `PLD_REG_FRAME_GEN_ENABLE, 32'h1);
        done_wait;
        rd(`PLD_REG_FCNT_L, 32'h2);
        rd(`PLD_REG_RXERR, 32'h1);
        rd(`PLD_REG_FCNT_L, 32'h3);
        wb(1'b1, `PLD_REG_FC_SEL, 32'h1);
        mac_tx <= 6'h2D;
        repeat (75) @(posedge mclk);
        mac_tx <= 6'h0F;
        repeat (120) @(posedge mclk);
        rd(`PLD_REG_RXERR, 32'h2);
        rd(`PLD_REG_FCNT_L, 32'h4);
        wb(1'b1, `PLD_REG_PD, 32'h1);
        rd(`PLD_REG_STAT, 32'h1);
        wb(1'b1, `PLD_REG_AN, 32'h0);
        wb(1'b1, `PLD_REG_FRC, 32'h1);
        chk(lvl, 32'h17);
        wb(1'b1, `PLD_REG_TM, {`PLD_TM_ALT, 13'h0});
        wb(1'b1, `PLD_REG_PD, 32'h0);
        syms;
        for (int i = 1; i < 40; i++) chk(s[i] ^ s[i-1], 2'h2);
        wb(1'b1, `PLD_REG_TM, {`PLD_TM_DROOP, 13'h0});
        syms;
        k = 1;
        while (k < 20 && s[k] === s[k-1]) k++;
        for (int j = 1; j < 20; j++) chk(s[k+j] !== s[k+j-1], j == 10);
        wb(1'b1, `PLD_REG_TM, {`PLD_TM_IDLE, 13'h0});
        syms;
        chk(s[39], 2'h1);
        wb(1'b1, `PLD_REG_PD, 32'h1);
        wb(1'b1, `PLD_REG_TM, 32'h0);
        wb(1'b1, `PLD_REG_PMA, 32'h1);
        wb(1'b1, `PLD_REG_PD, 32'h0);
        syms;
        chk(s[0] | s[39], 2'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire
